//--- rtl/boot_loader_map.vh
`ifndef BOOT_LOADER_MAP_VH
`define BOOT_LOADER_MAP_VH

// ----------------------------------------
// Serial memory access
// ----------------------------------------
`define BL_DEV_WR 8'hA0
`define BL_DEV_RD 8'hA1
`define BL_WORD_ADDR 8'h00

// ----------------------------------------
// Serial clock dividers per boot clock and speed
// ----------------------------------------
`define BL_DIV_100_STD 1008
`define BL_DIV_100_FAST 256
`define BL_DIV_75_STD 752
`define BL_DIV_75_FAST 192
`define BL_DIV_50_STD 512
`define BL_DIV_50_FAST 128
`define BL_DIV_33_STD 336
`define BL_DIV_33_FAST 96

// ----------------------------------------
// Boot image field positions
// ----------------------------------------
`define BL_B0_CLK_HI 3
`define BL_B0_CLK_LO 2
`define BL_B0_SPEED 1
`define BL_B1_AUTO 0
`define BL_B1_PCICLK 1
`define BL_B1_PREF 2
`define BL_HDR_LEN 12'h00A
`define BL_CNT_END 12'h00C
`define BL_PROG_FIRST 12'h030
`define BL_WORDS_FIRST 12'h00C

// ----------------------------------------
// Configuration space and reset values
// ----------------------------------------
`define BL_CFG_SUBSYS 8'h2C
`define BL_CFG_MEM_BASE 8'h14
`define BL_PREF_BIT 3
`define BL_RESET_REG_BASE 32'hEFF00000

`endif

//--- rtl/eeprom_boot_loader.v
`timescale 1ns/1ps
`include "boot_loader_map.vh"

// ----------------------------------------
// Byte FIFO
// ----------------------------------------
module boot_byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (wr_q - rd_q) != DEPTH[AW:0];
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// How it works
// - Serial clock divider picked from boot clock bits and speed bit.
// - Subsystem identity values appear at configuration offset 0x2C.
// - Clock generator bit clear leaves the PCI clock pin an input.
// - Bit set drives PCI clock pin from divider set by external I/O control.
// - Prefetchable bit shows as bit 3 of memory base in config reads.
// - After header, halt in host-assisted mode, continue in autonomous.
// - Autonomous part starts with an 11-bit program byte count.
// - Four address/value pairs follow; each value written to its address.
// - Register window base locates the 2 MB register window.
// - Fourth pair sets cacheable end at base plus 0x100008.
// - Copy of memory base is the start address for program words.
// - Each program word has its four bytes reversed before storing.
// - After the program is stored, release the main processor.
// - Give up the serial bus when loading ends, even if the processor stays in reset.
// - In host-assisted mode processor stays in reset until host releases.
module eeprom_boot_loader #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire ref_clk,
    input wire rst_n,
    input wire sda_in,
    output reg sda_o,
    output reg sda_oe,
    output reg scl_o,
    output reg scl_oe,
    output reg pci_clk_o,
    output reg pci_clk_oe,
    input wire [7:0] xio_clk_div,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    output reg [31:0] cfg_rdata,
    output reg wr_valid,
    output reg [31:0] wr_addr,
    output reg [31:0] wr_data,
    input wire wr_ready,
    output reg [19:0] memory_setup_reg,
    output reg [7:0] clock_multiplier_reg,
    output reg [31:0] register_window_base,
    output reg [31:0] cpu_start_addr,
    output reg main_processor_reset_n,
    output reg i2c_owned,
    input wire host_release,
    output reg boot_done
);
    localparam E_START = 3'b000;
    localparam E_WR = 3'b001;
    localparam E_RD = 3'b010;
    localparam E_STOP = 3'b011;
    localparam E_OFF = 3'b100;
    localparam P_RUN = 2'b00;
    localparam P_HOST = 2'b01;
    localparam P_DONE = 2'b10;

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg sda_m_q;
    reg sda_s_q;
    reg [2:0] e_st_q;
    reg [1:0] ph_q;
    reg [3:0] bit_q;
    reg [1:0] seq_q;
    reg [7:0] tx_q;
    reg [7:0] rx_q;
    reg [9:0] tcnt_q;
    reg [11:0] ecnt_q;
    reg push_q;
    reg [1:0] p_st_q;
    reg [11:0] pidx_q;
    reg [11:0] lim_q;
    reg [7:0] cfg0_q;
    reg [7:0] flags_q;
    reg [23:0] shw_q;
    reg [31:0] pair_addr_q;
    reg [31:0] prog_addr_q;
    reg [31:0] ident_q;
    reg [7:0] pdiv_q;
    reg [31:0] div_sel;
    wire f_in_ready;
    wire [7:0] f_data;
    wire f_valid;
    wire [11:0] widx = pidx_q - `BL_WORDS_FIRST;
    wire [31:0] word_in = {shw_q, f_data};
    wire last_byte = (ecnt_q + 12'h001) == lim_q;
    wire stall = (e_st_q == E_RD) && (bit_q == 4'h0) && (ph_q == 2'b00)
        && !f_in_ready;
    wire run = (e_st_q != E_OFF) && !stall;
    wire tick = run && (tcnt_q == 10'h000);
    wire pop = f_valid && !wr_valid && (p_st_q == P_RUN);

    // ----------------------------------------
    // Serial clock rate
    // ----------------------------------------
    // divider lookup
    always @* begin
        case ({cfg0_q[`BL_B0_CLK_HI:`BL_B0_CLK_LO], cfg0_q[`BL_B0_SPEED]})
            3'b000: div_sel = `BL_DIV_100_STD;
            3'b001: div_sel = `BL_DIV_100_FAST;
            3'b010: div_sel = `BL_DIV_75_STD;
            3'b011: div_sel = `BL_DIV_75_FAST;
            3'b100: div_sel = `BL_DIV_50_STD;
            3'b101: div_sel = `BL_DIV_50_FAST;
            3'b110: div_sel = `BL_DIV_33_STD;
            default: div_sel = `BL_DIV_33_FAST;
        endcase
    end

    boot_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_data(rx_q),
        .in_valid(push_q),
        .in_ready(f_in_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(pop)
    );

    // ----------------------------------------
    // Serial bus master
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            e_st_q <= E_START;
            ph_q <= 2'b00;
            bit_q <= 4'h0;
            seq_q <= 2'b00;
            tx_q <= `BL_DEV_WR;
            rx_q <= 8'h00;
            tcnt_q <= 10'h000;
            ecnt_q <= 12'h000;
            push_q <= 1'b0;
        end else begin
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            push_q <= 1'b0;
            if (run) begin
                tcnt_q <= (tcnt_q == 10'h000) ? div_sel[11:2] - 10'h001
                    : tcnt_q - 10'h001;
            end
            if (tick) begin
                ph_q <= ph_q + 2'b01;
                case (e_st_q)
                    // start, address zero, then repeated start
                    E_START: begin
                        case (ph_q)
                            2'b00: begin
                                sda_oe <= 1'b0;
                                scl_oe <= 1'b0;
                            end
                            2'b01: sda_oe <= 1'b1;
                            2'b10: scl_oe <= 1'b0;
                            default: begin
                                scl_oe <= 1'b1;
                                e_st_q <= E_WR;
                                bit_q <= 4'h0;
                                tx_q <= (seq_q == 2'b10) ? `BL_DEV_RD
                                    : `BL_DEV_WR;
                            end
                        endcase
                    end
                    E_WR: begin
                        case (ph_q)
                            2'b00: sda_oe <= (bit_q != 4'h8) && !tx_q[7];
                            2'b01: scl_oe <= 1'b0;
                            2'b10: scl_oe <= 1'b0;
                            default: begin
                                scl_oe <= 1'b1;
                                tx_q <= {tx_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'h8) begin
                                    bit_q <= 4'h0;
                                    if (seq_q == 2'b00) begin
                                        seq_q <= 2'b01;
                                        tx_q <= `BL_WORD_ADDR;
                                    end else if (seq_q == 2'b01) begin
                                        seq_q <= 2'b10;
                                        e_st_q <= E_START;
                                    end else begin
                                        e_st_q <= E_RD;
                                    end
                                end
                            end
                        endcase
                    end
                    E_RD: begin
                        case (ph_q)
                            2'b00: sda_oe <= (bit_q == 4'h8) && !last_byte;
                            2'b01: scl_oe <= 1'b0;
                            2'b10: begin
                                if (bit_q != 4'h8) begin
                                    rx_q <= {rx_q[6:0], sda_s_q};
                                end
                            end
                            default: begin
                                scl_oe <= 1'b1;
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'h8) begin
                                    bit_q <= 4'h0;
                                    push_q <= 1'b1;
                                    ecnt_q <= ecnt_q + 12'h001;
                                    if (last_byte) begin
                                        e_st_q <= E_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                    E_STOP: begin
                        case (ph_q)
                            2'b00: sda_oe <= 1'b1;
                            2'b01: scl_oe <= 1'b0;
                            2'b10: sda_oe <= 1'b0;
                            default: e_st_q <= E_OFF;
                        endcase
                    end
                    default: begin
                        sda_oe <= 1'b0;
                        scl_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Image parser and loader
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            p_st_q <= P_RUN;
            pidx_q <= 12'h000;
            lim_q <= `BL_HDR_LEN;
            cfg0_q <= 8'h00;
            flags_q <= 8'h00;
            shw_q <= 24'h000000;
            pair_addr_q <= 32'h00000000;
            prog_addr_q <= 32'h00000000;
            ident_q <= 32'h00000000;
            memory_setup_reg <= 20'h00000;
            clock_multiplier_reg <= 8'h00;
            register_window_base <= `BL_RESET_REG_BASE;
            cpu_start_addr <= 32'h00000000;
            wr_valid <= 1'b0;
            wr_addr <= 32'h00000000;
            wr_data <= 32'h00000000;
            main_processor_reset_n <= 1'b0;
            i2c_owned <= 1'b1;
            boot_done <= 1'b0;
        end else begin
            if (wr_valid && wr_ready) begin
                wr_valid <= 1'b0;
            end
            if (pop) begin
                pidx_q <= pidx_q + 12'h001;
                shw_q <= {shw_q[15:0], f_data};
                case (pidx_q)
                    12'h000: cfg0_q <= f_data;
                    12'h001: begin
                        flags_q <= f_data;
                        if (f_data[`BL_B1_AUTO]) begin
                            lim_q <= `BL_PROG_FIRST;
                        end
                    end
                    12'h002: ident_q[31:24] <= f_data;
                    12'h003: ident_q[23:16] <= f_data;
                    12'h004: ident_q[15:8] <= f_data;
                    12'h005: ident_q[7:0] <= f_data;
                    12'h006: memory_setup_reg[19:16] <= f_data[3:0];
                    12'h007: memory_setup_reg[15:8] <= f_data;
                    12'h008: memory_setup_reg[7:0] <= f_data;
                    12'h009: begin
                        clock_multiplier_reg <= f_data;
                        if (!flags_q[`BL_B1_AUTO]) begin
                            p_st_q <= P_HOST;
                        end
                    end
                    12'h00B: lim_q <= `BL_PROG_FIRST
                        + {1'b0, shw_q[2:0], f_data};
                    default: begin
                        if (pidx_q[1:0] == 2'b11
                            && pidx_q < `BL_PROG_FIRST) begin
                            if (widx[5:2] == 4'h8) begin
                                prog_addr_q <= word_in;
                                cpu_start_addr <= word_in;
                            end else if (!widx[2]) begin
                                pair_addr_q <= word_in;
                            end else begin
                                wr_valid <= 1'b1;
                                wr_addr <= pair_addr_q;
                                wr_data <= word_in;
                                if (widx[5:2] == 4'h1) begin
                                    register_window_base <= word_in;
                                end
                            end
                        end else if (pidx_q[1:0] == 2'b11) begin
                            wr_valid <= 1'b1;
                            wr_addr <= prog_addr_q;
                            wr_data <= {f_data, shw_q[7:0], shw_q[15:8],
                                shw_q[23:16]};
                            prog_addr_q <= prog_addr_q + 32'h00000004;
                        end
                    end
                endcase
            end
            if (p_st_q == P_RUN && pidx_q == lim_q && e_st_q == E_OFF
                && pidx_q >= `BL_PROG_FIRST && !wr_valid) begin
                p_st_q <= P_DONE;
                main_processor_reset_n <= 1'b1;
                i2c_owned <= 1'b0;
                boot_done <= 1'b1;
            end
            if (p_st_q == P_HOST) begin
                i2c_owned <= e_st_q != E_OFF;
                boot_done <= e_st_q == E_OFF;
                if (host_release && boot_done) begin
                    main_processor_reset_n <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Configuration reads and PCI clock pin
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h00000000;
            pci_clk_o <= 1'b0;
            pci_clk_oe <= 1'b0;
            pdiv_q <= 8'h00;
        end else begin
            if (cfg_rd) begin
                cfg_rdata <= 32'h00000000;
                if (cfg_addr == `BL_CFG_SUBSYS) begin
                    cfg_rdata <= ident_q;
                end
                if (cfg_addr == `BL_CFG_MEM_BASE) begin
                    cfg_rdata[`BL_PREF_BIT] <= flags_q[`BL_B1_PREF];
                end
            end
            pci_clk_oe <= flags_q[`BL_B1_PCICLK];
            if (pdiv_q >= xio_clk_div) begin
                pdiv_q <= 8'h00;
                pci_clk_o <= !pci_clk_o && flags_q[`BL_B1_PCICLK];
            end else begin
                pdiv_q <= pdiv_q + 8'h01;
            end
        end
    end
endmodule

//--- dv/boot_loader_asserts.sv
`timescale 1ns/1ps
module boot_loader_asserts (
    input wire ref_clk,
    input wire rst_n,
    input wire sda_oe,
    input wire scl_oe,
    input wire pci_clk_o,
    input wire pci_clk_oe,
    input wire [7:0] xio_clk_div,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [31:0] cfg_rdata,
    input wire wr_valid,
    input wire [31:0] wr_addr,
    input wire [31:0] wr_data,
    input wire wr_ready,
    input wire [31:0] cpu_start_addr,
    input wire main_processor_reset_n,
    input wire i2c_owned,
    input wire boot_done
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic [8:0] gap_q;
    logic prev_q, armed_q;
    logic [2:0] acc_q;
    logic [31:0] last_q;
    wire toggle_w = pci_clk_o != prev_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 9'h0;
            prev_q <= 1'b0;
            armed_q <= 1'b0;
            acc_q <= 3'h0;
            last_q <= 32'h0;
        end else begin
            prev_q <= pci_clk_o;
            gap_q <= toggle_w ? 9'h1 : gap_q + 9'h1;
            armed_q <= pci_clk_oe && (armed_q || toggle_w);
            if (wr_valid && wr_ready) begin
                last_q <= wr_addr;
                acc_q <= (acc_q == 3'h5) ? acc_q : acc_q + 3'h1;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    AST_WR_HOLD: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr)
            && $stable(wr_data))
        else $error("Write request changed before acceptance");
    AST_WR_DROP: assert property (
        wr_valid && wr_ready |=> !wr_valid)
        else $error("Write request not dropped");
    AST_CPU_HELD: assert property (
        !boot_done |-> !main_processor_reset_n && i2c_owned)
        else $error("Processor or bus freed during load");
    AST_BUS_FREED: assert property (
        main_processor_reset_n |-> !i2c_owned && !scl_oe && !sda_oe)
        else $error("Serial bus kept after processor release");
    AST_NO_LATE_WR: assert property (
        main_processor_reset_n |-> !wr_valid)
        else $error("Write after processor release");
    AST_PCI_IN: assert property (
        !pci_clk_oe |-> !pci_clk_o)
        else $error("Clock pin active while input");
    AST_PCI_GAP: assert property (
        armed_q && toggle_w |-> gap_q == {1'b0, xio_clk_div} + 9'h1)
        else $error("Generated clock period wrong");
    AST_CFG_STAND: assert property (
        !cfg_rd && !$past(cfg_rd) |=> $stable(cfg_rdata))
        else $error("Config data changed without a read");
    AST_CFG_OTHER: assert property (
        cfg_rd && cfg_addr != 8'h2C && cfg_addr != 8'h14
            |-> ##2 cfg_rdata == 32'h0)
        else $error("Unmapped config read not zero");
    AST_CFG_PREF: assert property (
        cfg_rd && cfg_addr == 8'h14 |-> ##2 cfg_rdata[31:4] == 28'h0
            && cfg_rdata[2:0] == 3'h0)
        else $error("Memory base read has stray bits");
    AST_PROG_START: assert property (
        $rose(wr_valid) && acc_q == 3'h4 |-> wr_addr == cpu_start_addr)
        else $error("First program word misplaced");
    AST_PROG_STEP: assert property (
        $rose(wr_valid) && acc_q == 3'h5 |-> wr_addr == last_q + 32'h4)
        else $error("Program words not consecutive");
endmodule

bind eeprom_boot_loader boot_loader_asserts u_boot_loader_asserts (
    .ref_clk(ref_clk), .rst_n(rst_n), .sda_oe(sda_oe), .scl_oe(scl_oe),
    .pci_clk_o(pci_clk_o), .pci_clk_oe(pci_clk_oe),
    .xio_clk_div(xio_clk_div), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_rdata(cfg_rdata), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ready(wr_ready),
    .cpu_start_addr(cpu_start_addr),
    .main_processor_reset_n(main_processor_reset_n),
    .i2c_owned(i2c_owned), .boot_done(boot_done)
);

//--- dv/boot_eeprom_model.sv
`timescale 1ns/1ps
module boot_eeprom_model (
    input wire scl,
    input wire sda,
    output logic sda_drv,
    output logic [7:0] ptr,
    output logic [7:0] word_addr
);
    // ----------------------------------------
    // Serial memory slave
    // ----------------------------------------
    logic [7:0] mem [0:255];
    logic [7:0] sh;
    logic rx = 1'b0, tx = 1'b0;
    logic go = 1'b0, nack = 1'b0;
    int bitn = 0;
    int nbyte = 0;
    initial sda_drv = 1'b0;
    initial ptr = 8'hFF;
    always @(negedge sda) if (scl === 1'b1) begin
        bitn = 0;
        nbyte = 0;
        rx = 1'b1;
        tx = 1'b0;
        sda_drv = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        rx = 1'b0;
        tx = 1'b0;
        sda_drv = 1'b0;
    end
    always @(posedge scl) if (rx | tx) begin
        if (bitn < 8 && rx)
            sh = {sh[6:0], sda};
        if (bitn == 8 && tx)
            nack = sda;
        bitn = bitn + 1;
    end
    always @(negedge scl) if (rx | tx) begin
        if (bitn == 8 && tx) begin
            sda_drv = 1'b0;
        end else if (bitn == 8) begin
            if (nbyte == 0)
                go = (sh == 8'hA1);
            if (nbyte == 1 && !go) begin
                ptr = sh;
                word_addr = sh;
            end
            nbyte = nbyte + 1;
            sda_drv = 1'b1;
        end else if (bitn == 9) begin
            bitn = 0;
            if (go) begin
                rx = 1'b0;
                tx = 1'b1;
                go = 1'b0;
                nack = 1'b0;
            end
            if (tx && nack) begin
                tx = 1'b0;
                sda_drv = 1'b0;
            end else if (tx) begin
                sh = mem[ptr];
                ptr = ptr + 8'h1;
                sda_drv = ~sh[7];
            end else begin
                sda_drv = 1'b0;
            end
        end else if (tx) begin
            sda_drv = ~sh[7 - bitn];
        end
    end
endmodule

//--- dv/eeprom_boot_loader_tb.sv
`timescale 1ns/1ps
module eeprom_boot_loader_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] xio_clk_div = 8'h00;
    logic wr_ready = 1'b0;
    logic host_release = 1'b0;
    logic stall = 1'b0;
    logic nr;
    wire sda_o, sda_oe, scl_o, scl_oe, pci_clk_o, pci_clk_oe, wr_valid;
    wire [31:0] cfg_rdata, wr_addr, wr_data, register_window_base;
    wire [31:0] cpu_start_addr;
    wire [19:0] memory_setup_reg;
    wire [7:0] clock_multiplier_reg, ee_ptr, ee_addr;
    wire main_processor_reset_n, i2c_owned, boot_done, ee_drv;
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | ee_drv);
    int n_errors = 0, samples_checked = 0;
    logic [63:0] exp_q [$];
    logic [7:0] img [0:55];

    always #25 ref_clk = ~ref_clk;

    eeprom_boot_loader u_eeprom_boot_loader (
        .ref_clk(ref_clk), .rst_n(rst_n), .sda_in(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
        .pci_clk_o(pci_clk_o), .pci_clk_oe(pci_clk_oe),
        .xio_clk_div(xio_clk_div), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_rdata(cfg_rdata), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_ready(wr_ready),
        .memory_setup_reg(memory_setup_reg),
        .clock_multiplier_reg(clock_multiplier_reg),
        .register_window_base(register_window_base),
        .cpu_start_addr(cpu_start_addr),
        .main_processor_reset_n(main_processor_reset_n),
        .i2c_owned(i2c_owned), .host_release(host_release),
        .boot_done(boot_done)
    );
    boot_eeprom_model u_boot_eeprom_model (
        .scl(scl), .sda(sda), .sda_drv(ee_drv), .ptr(ee_ptr),
        .word_addr(ee_addr)
    );

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cfgr(input logic [7:0] a, input logic [31:0] e);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge ref_clk);
        cfg_rd = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(cfg_rdata, e);
    endtask

    // Processor-space write sink with random stalls
    always @(negedge ref_clk) begin
        nr = !stall && ($urandom % 2 == 1);
        if (wr_valid === 1'b1 && nr)
            chk({wr_addr, wr_data}, exp_q.size() ? exp_q.pop_front() : 64'hX);
        wr_ready <= nr;
    end

    // ----------------------------------------
    // One boot run
    // ----------------------------------------
    task automatic run(input logic au);
        logic [31:0] w [0:8];
        logic pref;
        logic [7:0] a;
        longint t;
        int i;
        rst_n = 1'b0;
        host_release = 1'b0;
        pref = $urandom % 2;
        xio_clk_div = 8'(2 + $urandom % 20);
        img[0] = au ? 8'h0E : 8'h0A;
        img[1] = {5'h0, pref, au, au};
        for (i = 2; i < 56; i++)
            img[i] = 8'($urandom);
        img[10] = 8'h00;
        img[11] = 8'h08;
        w[0] = 32'hEFF00400;
        w[1] = $urandom & 32'hFFE00000;
        w[3] = $urandom & 32'hFF800000;
        w[5] = w[3] + 32'h00800000;
        w[7] = w[5];
        w[8] = w[3];
        for (i = 0; i < 3; i++)
            w[2 * i + 2] = w[1] + 32'h00100000 + 32'(4 * i);
        exp_q = {};
        for (i = 0; i < 9; i++) begin
            {img[12 + 4 * i], img[13 + 4 * i], img[14 + 4 * i],
                img[15 + 4 * i]} = w[i];
            if (i < 8 && i % 2 == 0 && au)
                exp_q.push_back({w[i], w[i + 1]});
        end
        for (i = 0; i < 2 && au; i++)
            exp_q.push_back({w[8] + 32'(4 * i), img[51 + 4 * i],
                img[50 + 4 * i], img[49 + 4 * i], img[48 + 4 * i]});
        for (i = 0; i < 56; i++)
            u_boot_eeprom_model.mem[i] = img[i];
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        for (i = 0; i < 60000 && ee_ptr - 8'd6 > 8'd4; i++) @(negedge ref_clk);
        @(posedge scl_oe);
        t = $time;
        @(posedge scl_oe);
        chk(($time - t) / 50, au ? 96 : 128);
        if (au) begin
            for (i = 0; i < 30000 && ee_ptr < 20; i++) @(negedge ref_clk);
            stall = 1'b1;
            repeat (3000) @(negedge ref_clk);
            stall = 1'b0;
        end
        for (i = 0; i < 80000 && boot_done !== 1'b1; i++)
            @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        chk(ee_addr, 0);
        chk(ee_ptr, au ? 56 : 10);
        chk(exp_q.size(), 0);
        chk(main_processor_reset_n, au);
        chk(register_window_base, au ? w[1] : 32'hEFF00000);
        chk({memory_setup_reg, clock_multiplier_reg},
            {img[6][3:0], img[7], img[8], img[9]});
        chk({sda_o, scl_o, pci_clk_oe, pci_clk_o & !au},
            {2'b00, au, 1'b0});
        cfgr(8'h2C, {img[2], img[3], img[4], img[5]});
        cfgr(8'h14, {28'h0, pref, 3'h0});
        repeat (3) begin
            a = 8'($urandom);
            cfgr((a == 8'h2C || a == 8'h14) ? 8'h40 : a, 32'h0);
        end
        if (au) begin
            chk({i2c_owned, cpu_start_addr}, {1'b0, w[8]});
            @(pci_clk_o);
            t = $time;
            @(pci_clk_o);
            chk(($time - t) / 50, xio_clk_div + 1);
        end else begin
            repeat (50) @(negedge ref_clk);
            chk(main_processor_reset_n, 0);
            host_release = 1'b1;
            repeat (4) @(negedge ref_clk);
            chk(main_processor_reset_n, 1);
        end
    endtask

    initial begin
        void'($urandom(32'h0CC25B16));
        run(1'b1);
        run(1'b0);
        end_of_test();
    end

    initial begin
        #(200000 * 50);
        n_errors++;
        end_of_test();
    end
endmodule
